/* tpu_pkg.sv */
// package for the timer channel block: offsets, fields, types
package tpu_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int TPU_NCH = 2;
  localparam int TPU_AW = 8;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] TPU_TCS_OFS = 8'h00;
  localparam logic [7:0] TPU_CNTH_OFS = 8'h04;
  localparam logic [7:0] TPU_CNTL_OFS = 8'h08;
  localparam logic [7:0] TPU_MODH_OFS = 8'h0c;
  localparam logic [7:0] TPU_MODL_OFS = 8'h10;
  localparam logic [7:0] TPU_CH_BASE = 8'h14;
  localparam logic [7:0] TPU_CH_STRIDE = 8'h0c;
  localparam logic [7:0] TPU_CH_CS = 8'h00;
  localparam logic [7:0] TPU_CH_VH = 8'h04;
  localparam logic [7:0] TPU_CH_VL = 8'h08;

  // ****************************************
  // field positions in the control bytes
  // ****************************************
  localparam int TPU_FLAG_BIT = 7;
  localparam int TPU_IE_BIT = 6;
  localparam int TPU_CENTER_BIT = 5;
  localparam int TPU_RUN_BIT = 3;
  localparam int TPU_MSB_BIT = 5;
  localparam int TPU_MSA_BIT = 4;
  localparam int TPU_ELB_BIT = 3;
  localparam int TPU_ELA_BIT = 2;

  // ****************************************
  // reset and limit values
  // ****************************************
  localparam logic [15:0] TPU_CNT_RST = 16'h0000;
  localparam logic [15:0] TPU_MOD_RST = 16'h0000;
  localparam logic [15:0] TPU_VAL_RST = 16'h0000;
  localparam logic [15:0] TPU_CNT_MAX = 16'hffff;
  localparam logic [15:0] TPU_CNT_ONE = 16'h0001;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic irq_en;
    logic center;
    logic run;
  } tpu_tcfg_s;

  typedef struct packed {
    logic irq_en;
    logic mode_hi;
    logic mode_lo;
    logic el_hi;
    logic el_lo;
  } tpu_ccfg_s;

  localparam tpu_tcfg_s TPU_TCFG_RST = '0;
  localparam tpu_ccfg_s TPU_CCFG_RST = '0;

  typedef enum logic [1:0] {MD_CAPT, MD_CMP, MD_EPWM, MD_CENTER_ALIGNED_PWM} tpu_mode_e;

endpackage

/* tpu_sync3.sv */
// three-stage pin synchroniser with agreed-level edge pulses
`timescale 1ns/10ps
module tpu_sync3 (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin side
  input wire logic din,
  // synchronised side
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_reg, s2_reg, s3_reg, level_reg;
  logic agree;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts only once stages two and three agree
  assign agree = (s2_reg == s3_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= 1'b0;
    end else if (agree) begin
      level_reg <= s3_reg;
    end
  end

  assign level = level_reg;
  assign rise = agree & s3_reg & ~level_reg;
  assign fall = agree & ~s3_reg & level_reg;

endmodule // tpu_sync3

/* tpu_top.sv */
// timer counter, channel capture/compare/pwm logic and apb registers
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// ****************************************
// Overview of operation
// - center select 0: mode bits pick capture, compare or edge pwm
// - center select 1: counter goes up/down, all channels center pwm
// - capture copies the counter into the value on the chosen edge
// - edge bits pick rising, falling, both or no capture edge
// - capture read of one byte freezes both until other byte read
// - capture sets channel flag; irq only with channel enable
// - compare match sets, clears or toggles the pin
// - compare value bytes buffered, loaded once both bytes written
// - compare match sets channel flag, irq with channel enable
// - edge pwm: modulus sets period, value sets duty, polarity bit
// - edge pwm: value zero gives 0%, above modulus gives 100%
// - edge pwm: buffered value loads at counter zero after both bytes
// - center pwm counts up to modulus then down, period twice modulus
// - center pwm: up match drives low, down match high, polarity flips
// - center pwm: zero or negative value 0%, above modulus 100%
// - center pwm: modulus and value load at reversal after both bytes
// - control writes discard pending buffered bytes
// - irq level held while enable set and flag is one
// - flag clear is read at one then write zero; new event wins
// - overflow flag at wrap to zero, or at turn down from modulus
// - edge pwm flag sets once per period at the end-of-duty match
// - center pwm flag sets at both matches in a period
// ****************************************
module tpu_top
  import tpu_pkg::*;
#(
  parameter int NCH = TPU_NCH
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [TPU_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel pins
  input wire logic [NCH-1:0] ch_pin_in,
  output logic [NCH-1:0] ch_pin_out,
  output logic [NCH-1:0] ch_pin_oe,
  // interrupt requests
  output logic overflow_irq,
  output logic [NCH-1:0] channel_irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic rd_stb, wr_stb, hit_any;
  logic [7:0] wbyte, rbyte;
  logic hit_tcs, hit_cnth, hit_cntl, hit_modh, hit_modl;
  logic [NCH-1:0] hit_ccs, hit_cvh, hit_cvl;
  logic [31:0] prdata_reg;

  tpu_tcfg_s tcfg_reg;
  logic tof_reg, tof_arm_reg;
  logic [15:0] cnt_reg, cnt_next, term;
  logic dir_down_reg, dir_down_next, wrap, reverse, ovf_evt;
  logic cnt_lat_reg, cnt_first_hi_reg;
  logic [15:0] cnt_buf_reg;

  logic [15:0] mod_reg, mod_buf_reg;
  logic mod_wh_reg, mod_wl_reg, mod_ld;

  tpu_ccfg_s ccfg_reg [NCH];
  tpu_mode_e ch_mode [NCH];
  logic [15:0] val_reg [NCH];
  logic [15:0] vbuf_reg [NCH];
  logic [15:0] rbuf_reg [NCH];
  logic [NCH-1:0] vwh_reg, vwl_reg, rlat_reg, rfirst_hi_reg;
  logic [NCH-1:0] flag_reg, arm_reg, pin_reg;
  logic [NCH-1:0] ld, match, cp_ok, cap_evt, ch_evt;
  logic [NCH-1:0] pin_rise, pin_fall;

  // ****************************************
  // apb decode
  // ****************************************
  assign rd_stb = psel & ~penable & ~pwrite;
  assign wr_stb = psel & penable & pwrite;
  assign wbyte = pwdata[7:0];

  always_comb begin
    hit_tcs = (paddr == TPU_TCS_OFS);
    hit_cnth = (paddr == TPU_CNTH_OFS);
    hit_cntl = (paddr == TPU_CNTL_OFS);
    hit_modh = (paddr == TPU_MODH_OFS);
    hit_modl = (paddr == TPU_MODL_OFS);
    for (int n = 0; n < NCH; n++) begin
      hit_ccs[n] = (paddr == 8'(n * TPU_CH_STRIDE) + TPU_CH_BASE + TPU_CH_CS);
      hit_cvh[n] = (paddr == 8'(n * TPU_CH_STRIDE) + TPU_CH_BASE + TPU_CH_VH);
      hit_cvl[n] = (paddr == 8'(n * TPU_CH_STRIDE) + TPU_CH_BASE + TPU_CH_VL);
    end
    hit_any = hit_tcs | hit_cnth | hit_cntl | hit_modh | hit_modl |
              (|hit_ccs) | (|hit_cvh) | (|hit_cvl);
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_reg;

  // ****************************************
  // read data mux
  // ****************************************
  always_comb begin
    rbyte = 8'h00;
    if (hit_tcs) begin
      rbyte[TPU_FLAG_BIT] = tof_reg;
      rbyte[TPU_IE_BIT] = tcfg_reg.irq_en;
      rbyte[TPU_CENTER_BIT] = tcfg_reg.center;
      rbyte[TPU_RUN_BIT] = tcfg_reg.run;
    end
    if (hit_cnth) begin
      rbyte = cnt_lat_reg ? cnt_buf_reg[15:8] : cnt_reg[15:8];
    end
    if (hit_cntl) begin
      rbyte = cnt_lat_reg ? cnt_buf_reg[7:0] : cnt_reg[7:0];
    end
    if (hit_modh) begin
      rbyte = mod_reg[15:8];
    end
    if (hit_modl) begin
      rbyte = mod_reg[7:0];
    end
    for (int n = 0; n < NCH; n++) begin
      if (hit_ccs[n]) begin
        rbyte[TPU_FLAG_BIT] = flag_reg[n];
        rbyte[TPU_IE_BIT] = ccfg_reg[n].irq_en;
        rbyte[TPU_MSB_BIT] = ccfg_reg[n].mode_hi;
        rbyte[TPU_MSA_BIT] = ccfg_reg[n].mode_lo;
        rbyte[TPU_ELB_BIT] = ccfg_reg[n].el_hi;
        rbyte[TPU_ELA_BIT] = ccfg_reg[n].el_lo;
      end
      if (hit_cvh[n]) begin
        rbyte = rlat_reg[n] ? rbuf_reg[n][15:8] : val_reg[n][15:8];
      end
      if (hit_cvl[n]) begin
        rbyte = rlat_reg[n] ? rbuf_reg[n][7:0] : val_reg[n][7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_stb) begin
      prdata_reg <= {24'h00_0000, rbyte};
    end
  end

  // ****************************************
  // timer configuration and overflow flag
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcfg_reg <= TPU_TCFG_RST;
    end else if (wr_stb && hit_tcs) begin
      tcfg_reg.irq_en <= wbyte[TPU_IE_BIT];
      tcfg_reg.center <= wbyte[TPU_CENTER_BIT];
      tcfg_reg.run <= wbyte[TPU_RUN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tof_reg <= 1'b0;
      tof_arm_reg <= 1'b0;
    end else if (ovf_evt) begin
      tof_reg <= 1'b1;
      tof_arm_reg <= 1'b0;
    end else if (wr_stb && hit_tcs && !wbyte[TPU_FLAG_BIT] && tof_arm_reg) begin
      tof_reg <= 1'b0;
      tof_arm_reg <= 1'b0;
    end else if (rd_stb && hit_tcs && tof_reg) begin
      tof_arm_reg <= 1'b1;
    end
  end

  assign overflow_irq = tof_reg & tcfg_reg.irq_en;

  // ****************************************
  // main counter
  // ****************************************
  always_comb begin
    term = (mod_reg == TPU_MOD_RST) ? TPU_CNT_MAX : mod_reg;
    cnt_next = cnt_reg;
    dir_down_next = dir_down_reg;
    wrap = 1'b0;
    reverse = 1'b0;
    if (tcfg_reg.run) begin
      if (!tcfg_reg.center) begin
        dir_down_next = 1'b0;
        if (cnt_reg == term) begin
          cnt_next = TPU_CNT_RST;
          wrap = 1'b1;
        end else begin
          cnt_next = cnt_reg + TPU_CNT_ONE;
        end
      end else if (!dir_down_reg) begin
        // a zero modulus never reverses the count
        if (cnt_reg == mod_reg && mod_reg != TPU_MOD_RST) begin
          cnt_next = cnt_reg - TPU_CNT_ONE;
          dir_down_next = 1'b1;
          reverse = 1'b1;
        end else begin
          cnt_next = cnt_reg + TPU_CNT_ONE;
        end
      end else if (cnt_reg == TPU_CNT_RST) begin
        cnt_next = TPU_CNT_ONE;
        dir_down_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - TPU_CNT_ONE;
      end
    end
  end

  assign ovf_evt = wrap | reverse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= TPU_CNT_RST;
      dir_down_reg <= 1'b0;
    end else if (wr_stb && (hit_cnth || hit_cntl)) begin
      cnt_reg <= TPU_CNT_RST;
      dir_down_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dir_down_reg <= dir_down_next;
    end
  end

  // counter read coherency: first byte read freezes the pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lat_reg <= 1'b0;
      cnt_first_hi_reg <= 1'b0;
      cnt_buf_reg <= TPU_CNT_RST;
    end else if (wr_stb && (hit_cnth || hit_cntl)) begin
      cnt_lat_reg <= 1'b0;
    end else if (rd_stb && (hit_cnth || hit_cntl)) begin
      if (!cnt_lat_reg) begin
        cnt_lat_reg <= 1'b1;
        cnt_first_hi_reg <= hit_cnth;
        cnt_buf_reg <= cnt_reg;
      end else if (cnt_first_hi_reg != hit_cnth) begin
        cnt_lat_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // modulus with write buffer
  // ****************************************
  assign mod_ld = mod_wh_reg & mod_wl_reg &
                  (!tcfg_reg.center | reverse);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_reg <= TPU_MOD_RST;
      mod_buf_reg <= TPU_MOD_RST;
      mod_wh_reg <= 1'b0;
      mod_wl_reg <= 1'b0;
    end else if (wr_stb && hit_tcs) begin
      mod_wh_reg <= 1'b0;
      mod_wl_reg <= 1'b0;
    end else begin
      if (mod_ld) begin
        mod_reg <= mod_buf_reg;
        mod_wh_reg <= 1'b0;
        mod_wl_reg <= 1'b0;
      end
      if (wr_stb && hit_modh) begin
        mod_buf_reg[15:8] <= wbyte;
        mod_wh_reg <= 1'b1;
      end
      if (wr_stb && hit_modl) begin
        mod_buf_reg[7:0] <= wbyte;
        mod_wl_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // channel pin synchronisers
  // ****************************************
  for (genvar g = 0; g < NCH; g++) begin : g_sync
    tpu_sync3 u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(ch_pin_in[g]),
      .level(),
      .rise(pin_rise[g]),
      .fall(pin_fall[g])
    );
  end

  // ****************************************
  // channel mode and events
  // ****************************************
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      if (tcfg_reg.center) begin
        ch_mode[n] = MD_CENTER_ALIGNED_PWM;
      end else if (ccfg_reg[n].mode_hi) begin
        ch_mode[n] = MD_EPWM;
      end else if (ccfg_reg[n].mode_lo) begin
        ch_mode[n] = MD_CMP;
      end else begin
        ch_mode[n] = MD_CAPT;
      end
      match[n] = tcfg_reg.run & (cnt_next == val_reg[n]);
      // center pwm compares only for positive nonzero values
      cp_ok[n] = (val_reg[n] != TPU_VAL_RST) & ~val_reg[n][15];
      cap_evt[n] = (ch_mode[n] == MD_CAPT) &
                   ((ccfg_reg[n].el_lo & pin_rise[n]) |
                    (ccfg_reg[n].el_hi & pin_fall[n]));
      unique case (ch_mode[n])
        MD_CAPT: begin
          ch_evt[n] = cap_evt[n];
          ld[n] = 1'b1;
        end
        MD_CMP: begin
          ch_evt[n] = match[n];
          ld[n] = 1'b1;
        end
        MD_EPWM: begin
          ch_evt[n] = match[n];
          ld[n] = wrap;
        end
        MD_CENTER_ALIGNED_PWM: begin
          ch_evt[n] = match[n] & cp_ok[n];
          ld[n] = reverse;
        end
      endcase
      ld[n] = ld[n] & vwh_reg[n] & vwl_reg[n];
    end
  end

  // ****************************************
  // channel control and flags
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < NCH; n++) begin
        ccfg_reg[n] <= TPU_CCFG_RST;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (wr_stb && hit_ccs[n]) begin
          ccfg_reg[n].irq_en <= wbyte[TPU_IE_BIT];
          ccfg_reg[n].mode_hi <= wbyte[TPU_MSB_BIT];
          ccfg_reg[n].mode_lo <= wbyte[TPU_MSA_BIT];
          ccfg_reg[n].el_hi <= wbyte[TPU_ELB_BIT];
          ccfg_reg[n].el_lo <= wbyte[TPU_ELA_BIT];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= '0;
      arm_reg <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (ch_evt[n]) begin
          flag_reg[n] <= 1'b1;
          arm_reg[n] <= 1'b0;
        end else if (wr_stb && hit_ccs[n] && !wbyte[TPU_FLAG_BIT] &&
                     arm_reg[n]) begin
          flag_reg[n] <= 1'b0;
          arm_reg[n] <= 1'b0;
        end else if (rd_stb && hit_ccs[n] && flag_reg[n]) begin
          arm_reg[n] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      channel_irq[n] = flag_reg[n] & ccfg_reg[n].irq_en;
    end
  end

  // ****************************************
  // channel value, write buffer and read freeze
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < NCH; n++) begin
        val_reg[n] <= TPU_VAL_RST;
        vbuf_reg[n] <= TPU_VAL_RST;
      end
      vwh_reg <= '0;
      vwl_reg <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if (cap_evt[n]) begin
          val_reg[n] <= cnt_reg;
        end else if (ld[n]) begin
          val_reg[n] <= vbuf_reg[n];
        end
        if (wr_stb && hit_ccs[n]) begin
          vwh_reg[n] <= 1'b0;
          vwl_reg[n] <= 1'b0;
        end else begin
          if (ld[n]) begin
            vwh_reg[n] <= 1'b0;
            vwl_reg[n] <= 1'b0;
          end
          if (wr_stb && hit_cvh[n]) begin
            vbuf_reg[n][15:8] <= wbyte;
            vwh_reg[n] <= 1'b1;
          end
          if (wr_stb && hit_cvl[n]) begin
            vbuf_reg[n][7:0] <= wbyte;
            vwl_reg[n] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < NCH; n++) begin
        rbuf_reg[n] <= TPU_VAL_RST;
      end
      rlat_reg <= '0;
      rfirst_hi_reg <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        if ((wr_stb && hit_ccs[n]) || ch_mode[n] != MD_CAPT) begin
          rlat_reg[n] <= 1'b0;
        end else if (rd_stb && (hit_cvh[n] || hit_cvl[n])) begin
          if (!rlat_reg[n]) begin
            rlat_reg[n] <= 1'b1;
            rfirst_hi_reg[n] <= hit_cvh[n];
            rbuf_reg[n] <= val_reg[n];
          end else if (rfirst_hi_reg[n] != hit_cvh[n]) begin
            rlat_reg[n] <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************
  // channel pin output
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= '0;
    end else begin
      for (int n = 0; n < NCH; n++) begin
        unique case (ch_mode[n])
          MD_CAPT: begin
            pin_reg[n] <= pin_reg[n];
          end
          MD_CMP: begin
            if (match[n]) begin
              unique case ({ccfg_reg[n].el_hi, ccfg_reg[n].el_lo})
                2'b01: pin_reg[n] <= ~pin_reg[n];
                2'b10: pin_reg[n] <= 1'b0;
                2'b11: pin_reg[n] <= 1'b1;
                2'b00: pin_reg[n] <= pin_reg[n];
              endcase
            end
          end
          MD_EPWM: begin
            // match wins so a zero value never shows a pulse
            if (match[n]) begin
              pin_reg[n] <= ccfg_reg[n].el_lo;
            end else if (wrap) begin
              pin_reg[n] <= ~ccfg_reg[n].el_lo;
            end
          end
          MD_CENTER_ALIGNED_PWM: begin
            if (match[n] && cp_ok[n]) begin
              pin_reg[n] <= dir_down_next ^ ccfg_reg[n].el_lo;
            end else if (reverse && !cp_ok[n]) begin
              pin_reg[n] <= ccfg_reg[n].el_lo;
            end else if (reverse && val_reg[n] > mod_reg) begin
              pin_reg[n] <= ~ccfg_reg[n].el_lo;
            end
          end
        endcase
      end
    end
  end

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      ch_pin_out[n] = pin_reg[n];
      ch_pin_oe[n] = (ch_mode[n] != MD_CAPT) &
                     (ccfg_reg[n].el_hi | ccfg_reg[n].el_lo);
    end
  end

endmodule // tpu_top

/* tpu_top_monitor.sv */
// checker of port-level timing for the timer block
`timescale 1ns/10ps
module tpu_top_monitor
  import tpu_pkg::*;
#(
  parameter int NCH = TPU_NCH
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [TPU_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  // pins and irqs
  input wire logic [NCH-1:0] ch_pin_out,
  input wire logic [NCH-1:0] ch_pin_oe,
  input wire logic overflow_irq,
  input wire logic [NCH-1:0] channel_irq
);
  logic wr;
  logic cap;
  logic cmp;
  logic [7:0] tcs_reg;
  logic [7:0] cs0_reg;
  assign wr = psel & penable & pwrite;
  assign cap = !tcs_reg[5] && cs0_reg[5:4] == 2'h0;
  assign cmp = !tcs_reg[5] && cs0_reg[5:4] == 2'h1 && |cs0_reg[3:2];
  // ****
  // shadow of written control bytes
  // ****
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcs_reg <= 8'h00;
      cs0_reg <= 8'h00;
    end else if (wr && paddr == TPU_TCS_OFS) begin
      tcs_reg <= pwdata[7:0];
    end else if (wr && paddr == TPU_CH_BASE) begin
      cs0_reg <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ovf_en; overflow_irq |-> tcs_reg[6]; endproperty
  a_ovf_en: assert property (p_ovf_en)
    else $error("overflow irq while disabled");
  property p_ch_en; channel_irq[0] |-> cs0_reg[6]; endproperty
  a_ch_en: assert property (p_ch_en)
    else $error("channel irq while disabled");
  property p_ovf_hold;
    $fell(overflow_irq) |-> $past(wr && paddr == TPU_TCS_OFS);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow irq dropped without write");
  property p_ch_hold;
    $fell(channel_irq[0]) |-> $past(wr && paddr == TPU_CH_BASE);
  endproperty
  a_ch_hold: assert property (p_ch_hold)
    else $error("channel irq dropped without write");
  property p_ch_rise;
    $rose(channel_irq[0]) |-> $past(tcs_reg[3] || cap || wr);
  endproperty
  a_ch_rise: assert property (p_ch_rise)
    else $error("channel irq rose with counter stopped");
  property p_pin_hold;
    !tcs_reg[3] && !$past(tcs_reg[3]) && !$past(wr) && !$past(wr, 2)
      |-> $stable(ch_pin_out[0]);
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("pin moved with counter stopped");
  property p_cap_oe; cap |-> !ch_pin_oe[0]; endproperty
  a_cap_oe: assert property (p_cap_oe)
    else $error("pin driven in capture mode");
  property p_cmp_oe; cmp |-> ch_pin_oe[0]; endproperty
  a_cmp_oe: assert property (p_cmp_oe)
    else $error("pin not driven in compare mode");
endmodule // tpu_top_monitor

bind tpu_top tpu_top_monitor #(.NCH(NCH)) mon (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
  .overflow_irq(overflow_irq), .channel_irq(channel_irq));

/* tpu_pin_model.sv */
// model of the signal sources on the channel pins
`timescale 1ns/10ps
module tpu_pin_model #(
  parameter int NCH = 2
) (
  // clock
  input wire logic pclk,
  // requested level and lag in cycles
  input wire logic [NCH-1:0] lvl,
  input wire logic [3:0] lag,
  // pin side
  output logic [NCH-1:0] pin
);
  logic [3:0] cnt_reg;
  initial begin
    pin = '0;
    cnt_reg = 4'h0;
  end
  // request shows lag+1 cycles after it changes, then holds
  always @(posedge pclk) begin
    if (pin == lvl) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg >= lag) begin
      pin <= lvl;
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule // tpu_pin_model

/* test_tpu_top.sv */
// self-checking bench of the timer block
`timescale 1ns/10ps
module test_tpu_top
  import tpu_pkg::*;
;
  localparam logic [7:0] CS0 = TPU_CH_BASE + TPU_CH_CS;
  localparam logic [7:0] VH0 = TPU_CH_BASE + TPU_CH_VH;
  localparam logic [7:0] VL0 = TPU_CH_BASE + TPU_CH_VL;
  localparam logic [7:0] ELS = 8'hb7;
  // center, polarity, value, high cycles in window
  localparam logic [31:0] ROWS [8] = '{32'h0000_031e, 32'h0000_0000,
    32'h0000_0a64, 32'h4000_0346, 32'h8000_0324, 32'h8000_0960,
    32'h8080_0300, 32'hc000_033c};
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] ch_pin_in;
  logic [1:0] ch_pin_out;
  logic overflow_irq;
  logic [1:0] channel_irq;
  logic [1:0] lvl;
  logic [3:0] lag;
  logic err;
  logic [7:0] r;
  logic [7:0] h;
  logic [31:0] row;
  int mismatches;
  int checked;
  tpu_top #(.NCH(2)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out), .ch_pin_oe(),
    .overflow_irq(overflow_irq), .channel_irq(channel_irq));
  tpu_pin_model #(.NCH(2)) pins (.pclk(pclk), .lvl(lvl), .lag(lag),
    .pin(ch_pin_in));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ****
  // tasks
  // ****
  task automatic end_sim();
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_sim();
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic meas(input int n, output logic [7:0] hi);
    hi = 8'h00;
    repeat (n) begin
      @(posedge pclk);
      hi = hi + {7'h00, ch_pin_out[0] === 1'b1};
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    lvl = 2'h0;
    lag = 4'h2;
    mismatches = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'hfc, 8'h00, r);
    chk({7'h00, err}, 8'h01);
    chk(r, 8'h00);
    for (int i = 0; i < 8; i++) begin
      row = ROWS[i];
      apb(1'b1, TPU_TCS_OFS, 8'h00, r);
      apb(1'b1, TPU_MODH_OFS, 8'h00, r);
      apb(1'b1, TPU_MODL_OFS, row[31] ? 8'h08 : 8'h09, r);
      apb(1'b1, TPU_CNTL_OFS, 8'h00, r);
      apb(1'b1, CS0, {2'h0, ~row[31], 1'b0, ~row[30], row[30], 2'h0}, r);
      apb(1'b1, VH0, row[23:16], r);
      apb(1'b1, VL0, row[15:8], r);
      apb(1'b1, TPU_TCS_OFS, {2'h0, row[31], 5'h08}, r);
      repeat (40) @(posedge pclk);
      meas(row[31] ? 96 : 100, h);
      chk(h, row[7:0]);
      apb(1'b0, TPU_TCS_OFS, 8'h00, r);
      chk(r & 8'h80, 8'h80);
    end
    apb(1'b1, TPU_TCS_OFS, 8'h48, r);
    repeat (20) @(posedge pclk);
    chk({7'h00, overflow_irq}, 8'h01);
    apb(1'b0, TPU_TCS_OFS, 8'h00, r);
    repeat (10) @(posedge pclk);
    apb(1'b1, TPU_TCS_OFS, 8'h48, r);
    chk({7'h00, overflow_irq}, 8'h01);
    apb(1'b1, TPU_TCS_OFS, 8'h40, r);
    chk({7'h00, overflow_irq}, 8'h01);
    apb(1'b0, TPU_TCS_OFS, 8'h00, r);
    apb(1'b1, TPU_TCS_OFS, 8'h40, r);
    chk({7'h00, overflow_irq}, 8'h00);
    apb(1'b1, TPU_MODH_OFS, 8'h00, r);
    apb(1'b1, TPU_MODL_OFS, 8'h00, r);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CS0, {4'h5, ELS[2*i +: 2], 2'h0}, r);
      apb(1'b1, VH0, 8'h00, r);
      apb(1'b1, VL0, 8'h05, r);
      apb(1'b1, TPU_CNTL_OFS, 8'h00, r);
      apb(1'b1, TPU_TCS_OFS, 8'h08, r);
      repeat (10) @(posedge pclk);
      apb(1'b1, TPU_TCS_OFS, 8'h00, r);
      chk({7'h00, ch_pin_out[0]}, {7'h00, ~i[0]});
      chk({7'h00, channel_irq[0]}, 8'h01);
    end
    apb(1'b1, VH0, 8'h12, r);
    apb(1'b1, CS0, 8'h58, r);
    apb(1'b1, VL0, 8'h34, r);
    apb(1'b0, VL0, 8'h00, r);
    chk(r, 8'h05);
    apb(1'b0, CS0, 8'h00, r);
    apb(1'b1, CS0, 8'h44, r);
    chk({7'h00, channel_irq[0]}, 8'h00);
    apb(1'b1, TPU_CNTL_OFS, 8'h00, r);
    apb(1'b1, TPU_TCS_OFS, 8'h08, r);
    lvl <= 2'h1;
    repeat (12) @(posedge pclk);
    chk({7'h00, channel_irq[0]}, 8'h01);
    apb(1'b0, VH0, 8'h00, r);
    chk(r, 8'h00);
    apb(1'b0, VL0, 8'h00, r);
    chk({7'h00, r > 8'h00 && r < 8'h40}, 8'h01);
    apb(1'b0, CS0, 8'h00, r);
    apb(1'b1, CS0, 8'h44, r);
    lag <= 4'h9;
    lvl <= 2'h0;
    repeat (20) @(posedge pclk);
    chk({7'h00, channel_irq[0]}, 8'h00);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CS0, 8'h00, r);
    chk(r, 8'h00);
    end_sim();
  end
endmodule // test_tpu_top
